// File: pkg/prox_pkg.sv
package prox_pkg;

    // Register word indices
    localparam logic [3:0] IDX_CTRL    = 4'h0;
    localparam logic [3:0] IDX_SCAN    = 4'h1;
    localparam logic [3:0] IDX_COMPPRD = 4'h2;
    localparam logic [3:0] IDX_STUCK   = 4'h3;
    localparam logic [3:0] IDX_FILT    = 4'h4;
    localparam logic [3:0] IDX_UPLIM   = 4'h5;
    localparam logic [3:0] IDX_DNLIM   = 4'h6;
    localparam logic [3:0] IDX_DEB     = 4'h7;
    localparam logic [3:0] IDX_THRESH  = 4'h8;
    localparam logic [3:0] IDX_STATUS  = 4'h9;
    localparam logic [3:0] IDX_RAW     = 4'hA;
    localparam logic [3:0] IDX_USEFUL  = 4'hB;
    localparam logic [3:0] IDX_AVG     = 4'hC;
    localparam logic [3:0] IDX_DIFF    = 4'hD;

    // Control register field positions
    localparam int CTRL_SENSOR   = 0;
    localparam int CTRL_SHIELD   = 1;
    localparam int CTRL_GAIN_LO  = 2;
    localparam int CTRL_BOOST    = 5;
    localparam int CTRL_FREQ_LO  = 6;
    localparam int CTRL_IMMUNITY = 8;
    localparam int CTRL_DONE_EN  = 9;
    localparam int CTRL_COMP_REQ = 15;

    // Status register field positions
    localparam int STAT_NEAR    = 0;
    localparam int STAT_CONV    = 1;
    localparam int STAT_PENDING = 2;

    // Filter and debounce field positions
    localparam int FILT_RAW_LO = 0;
    localparam int FILT_UP_LO  = 4;
    localparam int FILT_DN_LO  = 8;
    localparam int DEB_UP_LO   = 0;
    localparam int DEB_DN_LO   = 8;

    // Reset values
    localparam logic [3:0]  RST_RAW_COEF = 4'h8;
    localparam logic [3:0]  RST_UP_COEF  = 4'hE;
    localparam logic [3:0]  RST_DN_COEF  = 4'h8;
    localparam logic [11:0] RST_UP_LIM   = 12'h0FF;
    localparam logic [11:0] RST_DN_LIM   = 12'h0FF;
    localparam logic [7:0]  RST_DEB      = 8'h03;
    localparam logic [11:0] RST_THRESH   = 12'h040;

    // Coefficients are in sixteenths
    localparam int          COEF_SHIFT = 4;
    localparam logic [4:0]  COEF_ONE   = 5'h10;

    // Scan tick timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS       = 100000;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    localparam logic [9:0] TICK_LAST = 10'(TICK_CYC - 1);

    typedef enum logic [2:0] {
        S_IDLE,
        S_ARB,
        S_COMP,
        S_MEAS,
        S_USEFUL,
        S_AVG,
        S_DIFF,
        S_STAT
    } fsm_t;

    // Settings handed to the analogue front end
    typedef struct packed {
        logic       sensor_pin_select;
        logic       shield_pin_select;
        logic [2:0] sense_gain;
        logic       gain_boost;
        logic [1:0] sense_frequency;
        logic       noise_immunity_mode;
    } afe_cfg_t;

endpackage : prox_pkg

// File: src/filter_step.sv
`timescale 1ns/1ps
module filter_step
    import prox_pkg::*;
(
    input  wire logic [11:0] sample_i,
    input  wire logic [11:0] prev_i,
    input  wire logic [3:0]  coef_i,
    output logic      [11:0] out_o
);

    logic [17:0] sum;
    logic [4:0]  coef_new;

    // out = (1 - c) * sample + c * prev, c in sixteenths
    // Operands are widened first so no product bit is lost
    always_comb
    begin
        coef_new = COEF_ONE - {1'b0, coef_i};
        sum      = {6'h00, prev_i} * {14'h0000, coef_i}
                 + {6'h00, sample_i} * {13'h0000, coef_new};
        out_o    = sum[COEF_SHIFT +: 12];
    end

endmodule : filter_step

// File: src/prox_sense.sv
// Functional notes
// R1 - Sensor select: top layer or external pin
// R2 - Boost raises gain, external sensor only
// R3 - Shield select: bottom layer or external pin
// R4 - Five sources set pending; cleared after compensation
// R5 - Nonzero scan interval enable requests compensation
// R6 - Host may request compensation anytime
// R7 - Average drift past limit requests compensation
// R8 - Periodic compensation at programmed interval
// R9 - Long near state requests compensation
// R10 - Compensation runs only at scan start
// R11 - Raw sample is 12-bit, ADC shared
// R12 - Scan updates raw, useful, average, delta, flag
// R13 - Conversion active held during operation
// R14 - Raw update starts AFE, compensation first
// R15 - Useful value is first-order low-pass
// R16 - Up/down drift limits with own debounce
// R17 - Separate up/down average coefficients
// R18 - Average frozen while near
// R19 - Near flag compares delta with threshold
// R20 - Gain, frequency, immunity passed to AFE
// R21 - Delta is useful minus average
// R22 - Dedicated threshold; flag one means near
// R23 - Zero scan interval: no operation
// R24 - Compensation done signal with enable
// R25 - Filters restart from first compensated sample
// R26 - Debounce counts consecutive scans, resets inside
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
module prox_sense
    import prox_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        RST_B_I,
    input  wire logic        CE_I,
    input  wire logic [3:0]  ADDR_I,
    input  wire logic [15:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [15:0] RDATA_O,
    input  wire logic        ADC_GRANT_I,
    output logic             ADC_REQ_O,
    output logic             AFE_COMP_O,
    output logic             AFE_START_O,
    input  wire logic        AFE_READY_I,
    input  wire logic [11:0] AFE_DATA_I,
    output afe_cfg_t         AFE_CFG_O,
    output logic             NEAR_O,
    output logic             CONV_ACTIVE_O,
    output logic             COMP_DONE_O
);

    typedef struct packed {
        fsm_t        fsm;
        afe_cfg_t    cfg;
        afe_cfg_t    afe_out;
        logic        done_en;
        logic [7:0]  scan_interval;
        logic [7:0]  periodic_comp_interval;
        logic [7:0]  near_stuck_timeout;
        logic [3:0]  raw_filter_coef;
        logic [3:0]  avg_up_coef;
        logic [3:0]  avg_down_coef;
        logic [11:0] avg_up_limit;
        logic [11:0] avg_down_limit;
        logic [7:0]  avg_up_debounce;
        logic [7:0]  avg_down_debounce;
        logic [11:0] near_threshold;
        logic [9:0]  tick_cnt;
        logic [7:0]  scan_cnt;
        logic        comp_pending_flag;
        logic        first;
        logic [11:0] raw_sample;
        logic [11:0] filtered_sample;
        logic [11:0] env_average;
        logic [11:0] base;
        logic [12:0] user_delta;
        logic        near_flag;
        logic        conversion_active;
        logic        adc_req;
        logic        afe_comp;
        logic        afe_start;
        logic [7:0]  up_deb_cnt;
        logic [7:0]  dn_deb_cnt;
        logic [7:0]  prd_cnt;
        logic [7:0]  stuck_cnt;
        logic        done_pulse;
        logic [15:0] rdata;
        logic        ready_s1;
        logic        ready_s2;
        logic        ready_s3;
        logic [11:0] data_s1;
        logic [11:0] data_s2;
    } st_t;

    st_t         r;
    st_t         next_r;
    logic [11:0] useful_f;
    logic [11:0] avg_f;
    logic [3:0]  avg_coef;

    assign avg_coef = (r.filtered_sample >= r.env_average) ?
                      r.avg_up_coef : r.avg_down_coef; // R17

    filter_step u_useful_filt (
        .sample_i (r.raw_sample),
        .prev_i   (r.filtered_sample),
        .coef_i   (r.raw_filter_coef),
        .out_o    (useful_f)
    ); // R15

    filter_step u_avg_filt (
        .sample_i (r.filtered_sample),
        .prev_i   (r.env_average),
        .coef_i   (avg_coef),
        .out_o    (avg_f)
    );

    always_comb
    begin
        logic        wake;
        logic        req;
        logic        ready_rise;
        logic        up_over;
        logic        dn_over;
        logic        near_new;
        logic [11:0] drift;
        wake       = 1'b0;
        req        = 1'b0;
        ready_rise = 1'b0;
        near_new   = 1'b0;
        drift      = 12'h000;
        up_over    = 1'b0;
        dn_over    = 1'b0;
        next_r     = r;
        // Front end ready and data pass two flip-flops
        next_r.ready_s1 = AFE_READY_I;
        next_r.ready_s2 = r.ready_s1;
        next_r.ready_s3 = r.ready_s2;
        next_r.data_s1  = AFE_DATA_I;
        next_r.data_s2  = r.data_s1;
        ready_rise = r.ready_s2 & ~r.ready_s3;
        next_r.done_pulse = 1'b0;
        next_r.rdata      = 16'h0000;

        // Register writes
        if (WR_I)
        begin
            case (ADDR_I)
                IDX_CTRL:
                begin
                    next_r.cfg.sensor_pin_select   = WDATA_I[CTRL_SENSOR];
                    next_r.cfg.shield_pin_select   = WDATA_I[CTRL_SHIELD];
                    next_r.cfg.sense_gain  = WDATA_I[CTRL_GAIN_LO +: 3];
                    next_r.cfg.gain_boost  = WDATA_I[CTRL_BOOST];
                    next_r.cfg.sense_frequency = WDATA_I[CTRL_FREQ_LO +: 2];
                    next_r.cfg.noise_immunity_mode = WDATA_I[CTRL_IMMUNITY];
                    next_r.done_en = WDATA_I[CTRL_DONE_EN];
                    if (WDATA_I[CTRL_COMP_REQ])
                        req = 1'b1; // R6
                end
                IDX_SCAN:
                begin
                    next_r.scan_interval = WDATA_I[7:0];
                    if (r.scan_interval == 8'h00 && WDATA_I[7:0] != 8'h00)
                        req = 1'b1; // R5
                end
                IDX_COMPPRD: next_r.periodic_comp_interval = WDATA_I[7:0];
                IDX_STUCK:   next_r.near_stuck_timeout = WDATA_I[7:0];
                IDX_FILT:
                begin
                    next_r.raw_filter_coef = WDATA_I[FILT_RAW_LO +: 4];
                    next_r.avg_up_coef     = WDATA_I[FILT_UP_LO +: 4];
                    next_r.avg_down_coef   = WDATA_I[FILT_DN_LO +: 4];
                end
                IDX_UPLIM:  next_r.avg_up_limit   = WDATA_I[11:0];
                IDX_DNLIM:  next_r.avg_down_limit = WDATA_I[11:0];
                IDX_DEB:
                begin
                    next_r.avg_up_debounce   = WDATA_I[DEB_UP_LO +: 8];
                    next_r.avg_down_debounce = WDATA_I[DEB_DN_LO +: 8];
                end
                IDX_THRESH: next_r.near_threshold = WDATA_I[11:0];
                default: ;
            endcase
        end

        // Scan timer; a zero interval keeps the block asleep
        if (r.scan_interval == 8'h00)
        begin
            next_r.tick_cnt = 10'h000; // R23
            next_r.scan_cnt = 8'h00;
        end
        else if (r.tick_cnt == TICK_LAST)
        begin
            next_r.tick_cnt = 10'h000;
            if (r.scan_cnt >= r.scan_interval - 8'h01)
            begin
                next_r.scan_cnt = 8'h00;
                wake = 1'b1;
            end
            else
                next_r.scan_cnt = r.scan_cnt + 8'h01;
        end
        else
            next_r.tick_cnt = r.tick_cnt + 10'h001;

        // Scan sequence; ticks arriving while busy are dropped
        case (r.fsm)
            S_IDLE:
                if (wake)
                    next_r.fsm = S_ARB; // R12
            S_ARB:
                if (ADC_GRANT_I) // R11
                    next_r.fsm = r.comp_pending_flag ? // R10 R14
                                 S_COMP : S_MEAS;
            S_COMP:
                if (ready_rise)
                begin
                    next_r.comp_pending_flag = 1'b0; // R4
                    next_r.first      = 1'b1; // R25
                    next_r.up_deb_cnt = 8'h00;
                    next_r.dn_deb_cnt = 8'h00;
                    next_r.prd_cnt    = 8'h00;
                    next_r.stuck_cnt  = 8'h00;
                    next_r.done_pulse = r.done_en; // R24
                    next_r.fsm        = S_MEAS; // R14
                end
            S_MEAS:
                if (ready_rise)
                begin
                    next_r.raw_sample = r.data_s2; // R11
                    next_r.fsm        = S_USEFUL;
                end
            S_USEFUL:
            begin
                next_r.filtered_sample = r.first ? // R15 R25
                                         r.raw_sample : useful_f;
                next_r.fsm = S_AVG;
            end
            S_AVG:
            begin
                if (r.first)
                begin
                    next_r.env_average = r.filtered_sample; // R25
                    next_r.base        = r.filtered_sample;
                    next_r.first       = 1'b0;
                end
                else if (!r.near_flag)
                    next_r.env_average = avg_f; // R17 R18
                next_r.fsm = S_DIFF;
            end
            S_DIFF:
            begin
                next_r.user_delta = {1'b0, r.filtered_sample}
                                  - {1'b0, r.env_average}; // R21
                if (r.env_average > r.base)
                begin
                    drift   = r.env_average - r.base;
                    up_over = drift > r.avg_up_limit; // R16
                end
                else
                begin
                    drift   = r.base - r.env_average;
                    dn_over = drift > r.avg_down_limit; // R16
                end
                if (up_over)
                begin
                    if (r.up_deb_cnt >= r.avg_up_debounce)
                    begin
                        req = 1'b1; // R7
                        next_r.up_deb_cnt = 8'h00;
                    end
                    else
                        next_r.up_deb_cnt = r.up_deb_cnt + 8'h01; // R26
                end
                else
                    next_r.up_deb_cnt = 8'h00; // R26
                if (dn_over)
                begin
                    if (r.dn_deb_cnt >= r.avg_down_debounce)
                    begin
                        req = 1'b1; // R7
                        next_r.dn_deb_cnt = 8'h00;
                    end
                    else
                        next_r.dn_deb_cnt = r.dn_deb_cnt + 8'h01; // R26
                end
                else
                    next_r.dn_deb_cnt = 8'h00; // R26
                next_r.fsm = S_STAT;
            end
            S_STAT:
            begin
                near_new = $signed(r.user_delta)
                         > $signed({1'b0, r.near_threshold}); // R19 R22
                next_r.near_flag = near_new;
                if (r.periodic_comp_interval != 8'h00)
                begin
                    if (r.prd_cnt >= r.periodic_comp_interval - 8'h01)
                    begin
                        req = 1'b1; // R8
                        next_r.prd_cnt = 8'h00;
                    end
                    else
                        next_r.prd_cnt = r.prd_cnt + 8'h01;
                end
                if (near_new && r.near_stuck_timeout != 8'h00)
                begin
                    if (r.stuck_cnt >= r.near_stuck_timeout - 8'h01)
                    begin
                        req = 1'b1; // R9
                        next_r.stuck_cnt = 8'h00;
                    end
                    else
                        next_r.stuck_cnt = r.stuck_cnt + 8'h01;
                end
                else
                    next_r.stuck_cnt = 8'h00;
                next_r.fsm = S_IDLE;
            end
            default:
                next_r.fsm = S_IDLE;
        endcase

        // A new request wins over the clear in the same cycle
        if (req)
            next_r.comp_pending_flag = 1'b1; // R4

        next_r.conversion_active = (next_r.fsm != S_IDLE); // R13
        next_r.adc_req   = (next_r.fsm == S_ARB) || (next_r.fsm == S_COMP)
                        || (next_r.fsm == S_MEAS);
        next_r.afe_comp  = (next_r.fsm == S_COMP);
        next_r.afe_start = (next_r.fsm == S_MEAS);
        next_r.afe_out   = next_r.cfg; // R1 R3 R20
        next_r.afe_out.gain_boost = next_r.cfg.gain_boost
                                  & next_r.cfg.sensor_pin_select; // R2

        // Register reads, answered one cycle later
        if (RD_I)
        begin
            case (ADDR_I)
                IDX_CTRL:
                    next_r.rdata = {6'h00, r.done_en,
                                    r.cfg.noise_immunity_mode,
                                    r.cfg.sense_frequency,
                                    r.cfg.gain_boost, r.cfg.sense_gain,
                                    r.cfg.shield_pin_select,
                                    r.cfg.sensor_pin_select};
                IDX_SCAN:    next_r.rdata = {8'h00, r.scan_interval};
                IDX_COMPPRD: next_r.rdata = {8'h00, r.periodic_comp_interval};
                IDX_STUCK:   next_r.rdata = {8'h00, r.near_stuck_timeout};
                IDX_FILT:
                    next_r.rdata = {4'h0, r.avg_down_coef, r.avg_up_coef,
                                    r.raw_filter_coef};
                IDX_UPLIM:   next_r.rdata = {4'h0, r.avg_up_limit};
                IDX_DNLIM:   next_r.rdata = {4'h0, r.avg_down_limit};
                IDX_DEB:
                    next_r.rdata = {r.avg_down_debounce, r.avg_up_debounce};
                IDX_THRESH:  next_r.rdata = {4'h0, r.near_threshold};
                IDX_STATUS:
                    next_r.rdata = {13'h0000, r.comp_pending_flag,
                                    r.conversion_active, r.near_flag};
                IDX_RAW:     next_r.rdata = {4'h0, r.raw_sample};
                IDX_USEFUL:  next_r.rdata = {4'h0, r.filtered_sample};
                IDX_AVG:     next_r.rdata = {4'h0, r.env_average};
                IDX_DIFF:
                    next_r.rdata = {{3{r.user_delta[12]}}, r.user_delta};
                default:     next_r.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RST_B_I)
        begin
            r <= '0;
            r.raw_filter_coef   <= RST_RAW_COEF;
            r.avg_up_coef       <= RST_UP_COEF;
            r.avg_down_coef     <= RST_DN_COEF;
            r.avg_up_limit      <= RST_UP_LIM;
            r.avg_down_limit    <= RST_DN_LIM;
            r.avg_up_debounce   <= RST_DEB;
            r.avg_down_debounce <= RST_DEB;
            r.near_threshold    <= RST_THRESH;
        end
        else if (CE_I)
            r <= next_r;
    end

    assign RDATA_O       = r.rdata;
    assign ADC_REQ_O     = r.adc_req;
    assign AFE_COMP_O    = r.afe_comp;
    assign AFE_START_O   = r.afe_start;
    assign AFE_CFG_O     = r.afe_out;
    assign NEAR_O        = r.near_flag;
    assign CONV_ACTIVE_O = r.conversion_active;
    assign COMP_DONE_O   = r.done_pulse;

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);

    sequence s_grant_pending;
        CE_I && r.fsm == S_ARB && ADC_GRANT_I && r.comp_pending_flag;
    endsequence

    sequence s_meas_done;
        CE_I && r.fsm == S_MEAS && r.ready_s2 && !r.ready_s3;
    endsequence

    sequence s_comp_done;
        CE_I && r.fsm == S_COMP && r.ready_s2 && !r.ready_s3;
    endsequence

    a_comp_first_order: assert property (s_grant_pending |=> // R14
        r.fsm == S_COMP && AFE_COMP_O && !AFE_START_O)
        else $error("Pending compensation not run first");

    a_raw_capture: assert property (s_meas_done |=> // R11
        r.fsm == S_USEFUL && r.raw_sample == $past(r.data_s2))
        else $error("Raw sample not captured on ready");

    a_comp_done_pulse: assert property (s_comp_done |=> // R24
        COMP_DONE_O == $past(r.done_en) && r.first && r.fsm == S_MEAS)
        else $error("Compensation completion mishandled");

    a_host_request: assert property (CE_I && WR_I // R6
        && ADDR_I == IDX_CTRL && WDATA_I[CTRL_COMP_REQ]
        |=> r.comp_pending_flag)
        else $error("Host compensation request lost");

    a_conv_active: assert property ( // R13
        CONV_ACTIVE_O == (r.fsm != S_IDLE))
        else $error("Conversion active mismatch");

    a_zero_scan_idle: assert property (r.scan_interval == 8'h00 // R23
        && r.fsm == S_IDLE |=> r.fsm == S_IDLE)
        else $error("Operation started with zero scan interval");

    a_avg_frozen_near: assert property (CE_I && r.fsm == S_AVG // R18
        && r.near_flag && !r.first |=> $stable(r.env_average))
        else $error("Average moved while near");

    a_near_threshold: assert property (CE_I && r.fsm == S_STAT |=> // R19
        NEAR_O == ($signed($past(r.user_delta))
                   > $signed({1'b0, $past(r.near_threshold)})))
        else $error("Near flag not from threshold compare");

    a_delta_calc: assert property (CE_I && r.fsm == S_DIFF |=> // R21
        r.user_delta == 13'({1'b0, $past(r.filtered_sample)}
                            - {1'b0, $past(r.env_average)}))
        else $error("Delta not useful minus average");

    a_boost_gated: assert property (AFE_CFG_O.gain_boost // R2
        |-> AFE_CFG_O.sensor_pin_select)
        else $error("Boost applied without external sensor");

endmodule : prox_sense

// File: sim/afe_model.sv
`timescale 1ns/1ps
module afe_model
    import prox_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        adc_req_i,
    input  wire logic        comp_i,
    input  wire logic        start_i,
    input  wire logic [11:0] sample_i,
    output logic             grant_o,
    output logic             ready_o,
    output logic      [11:0] data_o
);
    logic [1:0] last_cmd = 2'h0;
    logic [3:0] cnt      = 4'h0;
    initial grant_o = 1'b0;
    initial ready_o = 1'b0;
    initial data_o  = 12'hA5A;
    always @(posedge clk_i)
    begin
        grant_o  <= adc_req_i;
        last_cmd <= {comp_i, start_i};
        if ({comp_i, start_i} != last_cmd || !(comp_i || start_i))
        begin
            cnt     <= 4'h0;
            ready_o <= 1'b0;
            data_o  <= ~data_o;
        end
        else if (cnt == 4'h5 && !ready_o)
        begin
            ready_o <= 1'b1;
            data_o  <= sample_i;
        end
        else if (!ready_o)
            cnt <= cnt + 4'h1;
    end
endmodule : afe_model

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench
    import prox_pkg::*;
;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, grant, ready, comp, start;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [11:0] sample = 12'h400, adata;
    logic        req, near, conv, done;
    afe_cfg_t    cfg;
    int err_count = 0, n_checks = 0, dn;
    initial forever #50 clk = ~clk;
    prox_sense i_dut (.CLOCK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .ADC_GRANT_I(grant), .ADC_REQ_O(req),
        .AFE_COMP_O(comp), .AFE_START_O(start), .AFE_READY_I(ready),
        .AFE_DATA_I(adata), .AFE_CFG_O(cfg), .NEAR_O(near),
        .CONV_ACTIVE_O(conv), .COMP_DONE_O(done));
    afe_model i_afe (.clk_i(clk), .adc_req_i(req), .comp_i(comp),
        .start_i(start), .sample_i(sample), .grant_o(grant),
        .ready_o(ready), .data_o(adata));
    task stop_test();
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr    <= 1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 0;
    endtask : wr_reg
    task rd_chk(input string nm, input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        rd   <= 1;
        addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 chk(nm, rdata, e);
    endtask : rd_chk
    task wait_scan();
        int i;
        dn = 0;
        for (i = 0; i < 3000 && !conv; i++)
        begin
            @(posedge clk);
            #1;
        end
        for (i = 0; i < 3000 && conv; i++)
        begin
            @(posedge clk);
            #1 dn += done;
        end
        chk("scan_end", {15'h0000, conv}, 16'h0000);
    endtask : wait_scan
    task t_regs();
        rd_chk("filt", 4'h4, 16'h08E8);
        rd_chk("uplim", 4'h5, 16'h00FF);
        rd_chk("deb", 4'h7, 16'h0303);
        rd_chk("thr", 4'h8, 16'h0040);
        wr_reg(4'hF, 16'hFFFF);
        rd_chk("unmap", 4'hF, 16'h0000);
        rd_chk("stat0", 4'h9, 16'h0000);
    endtask : t_regs
    task t_cfg();
        wr_reg(4'h0, 16'h003C);
        @(posedge clk);
        #1 chk("cfg_int", {7'h00, cfg}, 16'h0070);
        wr_reg(4'h0, 16'h03E3);
        @(posedge clk);
        #1 chk("cfg_ext", {7'h00, cfg}, 16'h018F);
    endtask : t_cfg
    task t_enable();
        wr_reg(4'h1, 16'h0001);
        rd_chk("pend", 4'h9, 16'h0004);
        wait_scan();
        chk("done", 16'(dn), 16'h0001);
        rd_chk("st", 4'h9, 16'h0000);
        rd_chk("raw", 4'hA, 16'h0400);
        rd_chk("use", 4'hB, 16'h0400);
        rd_chk("avg", 4'hC, 16'h0400);
        rd_chk("dif", 4'hD, 16'h0000);
    endtask : t_enable
    task t_near();
        sample = 12'h600;
        wait_scan();
        rd_chk("use1", 4'hB, 16'h0500);
        rd_chk("avg1", 4'hC, 16'h0420);
        rd_chk("dif1", 4'hD, 16'h00E0);
        rd_chk("st1", 4'h9, 16'h0001);
        chk("near", {15'h0, near}, 16'h0001);
        wait_scan();
        rd_chk("avg2", 4'hC, 16'h0420);
        rd_chk("dif2", 4'hD, 16'h0160);
    endtask : t_near
    task t_host();
        sample = 12'h300;
        wr_reg(4'h0, 16'h83E3);
        rd_chk("hpend", 4'h9, 16'h0005);
        wait_scan();
        chk("hdone", 16'(dn), 16'h0001);
        rd_chk("huse", 4'hB, 16'h0300);
        rd_chk("hst", 4'h9, 16'h0000);
    endtask : t_host
    task t_prd();
        wr_reg(4'h2, 16'h0002);
        wait_scan();
        rd_chk("ppend0", 4'h9, 16'h0000);
        wait_scan();
        rd_chk("ppend1", 4'h9, 16'h0004);
        wait_scan();
        chk("pdone", 16'(dn), 16'h0001);
        rd_chk("pst", 4'h9, 16'h0000);
    endtask : t_prd
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1;
        t_regs();
        t_cfg();
        t_enable();
        t_near();
        t_host();
        t_prd();
        stop_test();
    end
    initial
    begin
        repeat (30000) @(posedge clk);
        err_count++;
        stop_test();
    end
endmodule : testbench
